// ===== design/pcw_writer.sv
// The address map and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/100ps
`default_nettype none
module pcw_writer
  import pcw_pkg::*;
#(
  parameter int NCH = 4,
  parameter int CHW = (NCH > 1) ? $clog2(NCH) : 1
)
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic              ce,
  input  wire logic              wr_strobe,
  input  wire pcw_set_t          set_in,
  input  wire logic [CHW-1:0]    chan_addr,
  input  wire logic [DIR_W-1:0]  dir_sel,
  output logic                   busy,
  output pcw_set_t               set_out,
  output logic [CHW-1:0]         pma_chan,
  output wire logic              pma_sdata,
  output wire logic              pma_svalid,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready
);

  // ---------------------------------------------------------------
  // Write sequencer
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_MERGE = 3'b010,
    ST_SHIFT = 3'b100
  } pcw_state_t;

  pcw_state_t           state_r, state_nxt;
  pcw_set_t             cap_set_r, cap_set_nxt;
  logic [CHW-1:0]       cap_chan_r, cap_chan_nxt;
  logic [DIR_W-1:0]     cap_dir_r, cap_dir_nxt;
  logic                 busy_nxt, fabric_en_r, start_c, mem_we, ser_done;
  pcw_set_t             set_out_nxt, mem_rd, merged;
  logic [CHW-1:0]       pma_chan_nxt, chan_c;
  logic [CNT_W-1:0]     wcnt_r, wcnt_nxt;

  // A single-channel build ignores the address input altogether.
  assign chan_c = (NCH > 1) ? chan_addr : '0;

  // Strobe is honoured only when idle, enabled and a direction is set.
  assign start_c = wr_strobe && (state_r == ST_IDLE) && fabric_en_r
                   && (dir_sel != DIR_NONE);

  // Keeps old fields of the channel and overlays each selected half (both for DIR_BOTH).
  always_comb
  begin
    merged = mem_rd;
    if (cap_dir_r[DIR_TX_BIT])
    begin
      {merged.vod, merged.preemp} = {cap_set_r.vod, cap_set_r.preemp};
    end
    if (cap_dir_r[DIR_RX_BIT])
    begin
      {merged.eqdc, merged.eq} = {cap_set_r.eqdc, cap_set_r.eq};
    end
  end

  assign mem_we = (state_r == ST_MERGE);

  // Next state, capture and status of a write transaction.
  always_comb
  begin
    state_nxt    = state_r;
    cap_set_nxt  = cap_set_r;
    cap_chan_nxt = cap_chan_r;
    cap_dir_nxt  = cap_dir_r;
    set_out_nxt  = set_out;
    pma_chan_nxt = pma_chan;
    wcnt_nxt     = wcnt_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (start_c)
        begin
          cap_set_nxt  = set_in;
          cap_chan_nxt = chan_c;
          cap_dir_nxt  = dir_sel;
          state_nxt    = ST_MERGE;
        end
      end
      ST_MERGE:
      begin
        set_out_nxt  = merged;
        pma_chan_nxt = cap_chan_r;
        state_nxt    = ST_SHIFT;
      end
      ST_SHIFT:
      begin
        if (ser_done)
        begin
          wcnt_nxt  = wcnt_r + CNT_W'(1);
          state_nxt = ST_IDLE;
        end
      end
      default:
      begin
        state_nxt = ST_IDLE;
      end
    endcase
    busy_nxt = (state_nxt != ST_IDLE);
  end

  // Registers the sequencer; everything freezes while ce is low.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_r    <= ST_IDLE;
      cap_set_r  <= '0;
      cap_chan_r <= '0;
      cap_dir_r  <= DIR_NONE;
      busy       <= 1'b0;
      set_out    <= '0;
      pma_chan   <= '0;
      wcnt_r     <= '0;
    end
    else if (ce)
    begin
      state_r    <= state_nxt;
      cap_set_r  <= cap_set_nxt;
      cap_chan_r <= cap_chan_nxt;
      cap_dir_r  <= cap_dir_nxt;
      busy       <= busy_nxt;
      set_out    <= set_out_nxt;
      pma_chan   <= pma_chan_nxt;
      wcnt_r     <= wcnt_nxt;
    end
  end

  // Only the addressed entry is rewritten; others keep their values.
  pcw_mem #(.DEPTH (NCH), .AW (CHW)) u_mem (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .rd_en   (start_c),
    .rd_addr (chan_c),
    .rd_data (mem_rd),
    .wr_en   (mem_we),
    .wr_addr (cap_chan_r),
    .wr_data (merged)
  );

  // Shifts the merged word to the channel's analog latch.
  pcw_ser #(.W (SET_W)) u_ser (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .load    (mem_we),
    .din     (merged),
    .sdata   (pma_sdata),
    .svalid  (pma_svalid),
    .done    (ser_done)
  );

  // ---------------------------------------------------------------
  // AXI4-Lite register slave
  // ---------------------------------------------------------------
  logic [AXI_AW-1:0] awaddr_r, awaddr_nxt;
  logic [31:0]       wdata_r, wdata_nxt;
  logic              wstrb0_r, wstrb0_nxt;
  logic              awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt, fabric_en_nxt;
  logic [1:0]        bresp_nxt, rresp_nxt;
  logic [31:0]       rdata_nxt;

  // Address and data are taken in either order; response follows both.
  always_comb
  begin
    awaddr_nxt    = awaddr_r;
    wdata_nxt     = wdata_r;
    wstrb0_nxt    = wstrb0_r;
    awready_nxt   = s_axi_awready;
    wready_nxt    = s_axi_wready;
    bvalid_nxt    = s_axi_bvalid;
    bresp_nxt     = s_axi_bresp;
    arready_nxt   = s_axi_arready;
    rvalid_nxt    = s_axi_rvalid;
    rdata_nxt     = s_axi_rdata;
    rresp_nxt     = s_axi_rresp;
    fabric_en_nxt = fabric_en_r;
    if (s_axi_awvalid && s_axi_awready)
    begin
      awaddr_nxt  = s_axi_awaddr;
      awready_nxt = 1'b0;
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      wdata_nxt  = s_axi_wdata;
      wstrb0_nxt = s_axi_wstrb[0];
      wready_nxt = 1'b0;
    end
    if (!s_axi_awready && !s_axi_wready && !s_axi_bvalid)
    begin
      bvalid_nxt = 1'b1;
      bresp_nxt  = RESP_OKAY;
      if (awaddr_r == REG_CTRL && wstrb0_r)
      begin
        fabric_en_nxt = wdata_r[CTRL_EN_BIT];
      end
      if (awaddr_r != REG_CTRL && awaddr_r != REG_STAT && awaddr_r != REG_LAST)
      begin
        bresp_nxt = RESP_SLVERR;
      end
    end
    if (s_axi_bvalid && s_axi_bready)
    begin
      bvalid_nxt  = 1'b0;
      awready_nxt = 1'b1;
      wready_nxt  = 1'b1;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      arready_nxt = 1'b0;
      rvalid_nxt  = 1'b1;
      rresp_nxt   = RESP_OKAY;
      rdata_nxt   = '0;
      unique case (s_axi_araddr)
        REG_CTRL: rdata_nxt[CTRL_EN_BIT] = fabric_en_r;
        REG_STAT: rdata_nxt = {wcnt_r, {(32 - CNT_W - 1){1'b0}}, busy};
        REG_LAST: rdata_nxt = {{(32 - DIR_W - SET_W){1'b0}}, cap_dir_r, set_out};
        default:  rresp_nxt = RESP_SLVERR;
      endcase
    end
    if (s_axi_rvalid && s_axi_rready)
    begin
      rvalid_nxt  = 1'b0;
      arready_nxt = 1'b1;
    end
  end

  // Registers the bus slave state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awaddr_r      <= '0;
      wdata_r       <= '0;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
      fabric_en_r   <= CTRL_EN_RST;
    end
    else if (ce)
    begin
      awaddr_r      <= awaddr_nxt;
      wdata_r       <= wdata_nxt;
      wstrb0_r      <= wstrb0_nxt;
      s_axi_awready <= awready_nxt;
      s_axi_wready  <= wready_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      s_axi_bresp   <= bresp_nxt;
      s_axi_arready <= arready_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      s_axi_rdata   <= rdata_nxt;
      s_axi_rresp   <= rresp_nxt;
      fabric_en_r   <= fabric_en_nxt;
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_strobe_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_c && ce) |=> (cap_set_r == $past(set_in) && cap_dir_r == $past(dir_sel)
                         && state_r == ST_MERGE))
    else $error("Strobe inputs not captured.");
  a_busy_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_c && ce) |=> busy)
    else $error("Busy did not rise after strobe.");
  a_busy_shift: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r != ST_IDLE) |-> busy)
    else $error("Busy low during transfer.");
  a_busy_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    (state_r == ST_SHIFT && ser_done && ce) |=> (!busy && state_r == ST_IDLE))
    else $error("Busy did not fall after transfer.");
  a_tx_keeps_rx: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && cap_dir_r == DIR_TX) |-> (merged.eqdc == mem_rd.eqdc
     && merged.eq == mem_rd.eq && merged.vod == cap_set_r.vod))
    else $error("Transmit-only write altered receiver fields.");
  a_tx_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && ce && cap_dir_r[DIR_TX_BIT]) |=> (set_out.vod == $past(cap_set_r.vod)
     && set_out.preemp == $past(cap_set_r.preemp)))
    else $error("Transmit readback mismatch.");
  a_rx_readback: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && ce && cap_dir_r[DIR_RX_BIT]) |=> (set_out.eq == $past(cap_set_r.eq)))
    else $error("Equalizer readback mismatch.");
  a_chan_capture: assert property (@(posedge aclk) disable iff (!aresetn)
    (start_c && ce) |=> (cap_chan_r == ((NCH > 1) ? $past(chan_addr) : '0)))
    else $error("Channel address not taken as the build requires.");
  a_only_addressed: assert property (@(posedge aclk) disable iff (!aresetn)
    (mem_we && ce) |=> (pma_chan == $past(cap_chan_r) && busy))
    else $error("Write reached a channel other than the addressed one.");

endmodule // pcw_writer
`default_nettype wire

// ===== design/pcw_pkg.sv
package pcw_pkg;

  // ---------------------------------------------------------------
  // Setting field widths
  // ---------------------------------------------------------------
  localparam int VOD_W    = 3;
  localparam int PREEMP_W = 5;
  localparam int EQDC_W   = 2;
  localparam int EQ_W     = 4;
  localparam int SET_W    = VOD_W + PREEMP_W + EQDC_W + EQ_W;
  localparam int DIR_W    = 2;

  // One channel's analog settings, transmit fields first.
  typedef struct packed {
    logic [VOD_W-1:0]    vod;
    logic [PREEMP_W-1:0] preemp;
    logic [EQDC_W-1:0]   eqdc;
    logic [EQ_W-1:0]     eq;
  } pcw_set_t;

  // ---------------------------------------------------------------
  // Direction select codes and bits
  // ---------------------------------------------------------------
  localparam logic [DIR_W-1:0] DIR_NONE = 2'h0;
  localparam logic [DIR_W-1:0] DIR_RX   = 2'h1;
  localparam logic [DIR_W-1:0] DIR_TX   = 2'h2;
  localparam logic [DIR_W-1:0] DIR_BOTH = 2'h3;
  localparam int               DIR_RX_BIT = 0;
  localparam int               DIR_TX_BIT = 1;

  // ---------------------------------------------------------------
  // Register bus map
  // ---------------------------------------------------------------
  localparam int              AXI_AW   = 4;
  localparam logic [AXI_AW-1:0] REG_CTRL = 4'h0;
  localparam logic [AXI_AW-1:0] REG_STAT = 4'h4;
  localparam logic [AXI_AW-1:0] REG_LAST = 4'h8;
  localparam int              CTRL_EN_BIT = 0;
  localparam logic            CTRL_EN_RST = 1'h1;
  localparam int              CNT_W       = 16;
  localparam logic [1:0]      RESP_OKAY   = 2'h0;
  localparam logic [1:0]      RESP_SLVERR = 2'h2;

endpackage

// ===== design/pcw_mem.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_mem
  import pcw_pkg::*;
#(
  parameter int DEPTH = 4,
  parameter int AW    = 2
)
(
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic          ce,
  input  wire logic          rd_en,
  input  wire logic [AW-1:0] rd_addr,
  output pcw_set_t           rd_data,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] wr_addr,
  input  wire pcw_set_t      wr_data
);

  // ---------------------------------------------------------------
  // Per-channel settings store
  // ---------------------------------------------------------------
  pcw_set_t mem_r [DEPTH];
  pcw_set_t rd_nxt;

  // Read data come from a register one edge after the request.
  always_comb
  begin
    rd_nxt = rd_data;
    if (rd_en)
    begin
      rd_nxt = mem_r[rd_addr];
    end
  end

  // Entries start cleared so a first partial write merges known values.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_data <= '0;
      for (int i = 0; i < DEPTH; i++)
      begin
        mem_r[i] <= '0;
      end
    end
    else if (ce)
    begin
      rd_data <= rd_nxt;
      if (wr_en)
      begin
        mem_r[wr_addr] <= wr_data;
      end
    end
  end

endmodule // pcw_mem
`default_nettype wire

// ===== design/pcw_ser.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_ser
#(
  parameter int W  = 14,
  parameter int CW = $clog2(W + 1)
)
(
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic         ce,
  input  wire logic         load,
  input  wire logic [W-1:0] din,
  output logic              sdata,
  output logic              svalid,
  output logic              done
);

  // ---------------------------------------------------------------
  // Serial shifter toward the channel's analog control latch
  // ---------------------------------------------------------------
  logic [W-1:0]  sh_r, sh_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic          sdata_nxt, svalid_nxt, done_nxt;

  // Shifts LSB first; done pulses together with the last bit.
  always_comb
  begin
    sh_nxt     = sh_r;
    cnt_nxt    = cnt_r;
    sdata_nxt  = sdata;
    svalid_nxt = 1'b0;
    done_nxt   = 1'b0;
    if (load)
    begin
      sh_nxt  = din;
      cnt_nxt = CW'(W);
    end
    else if (cnt_r != '0)
    begin
      sdata_nxt  = sh_r[0];
      sh_nxt     = sh_r >> 1;
      svalid_nxt = 1'b1;
      done_nxt   = (cnt_r == CW'(1));
      cnt_nxt    = cnt_r - CW'(1);
    end
  end

  // Registers the shifter state.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      sh_r   <= '0;
      cnt_r  <= '0;
      sdata  <= 1'b0;
      svalid <= 1'b0;
      done   <= 1'b0;
    end
    else if (ce)
    begin
      sh_r   <= sh_nxt;
      cnt_r  <= cnt_nxt;
      sdata  <= sdata_nxt;
      svalid <= svalid_nxt;
      done   <= done_nxt;
    end
  end

endmodule // pcw_ser
`default_nettype wire

// ===== testbench/pcw_user_model.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_user_model
  import pcw_pkg::*;
#(
  parameter int CHW = 2
)
(
  input  wire logic            aclk,
  input  wire logic            aresetn,
  input  wire logic            go,
  input  wire logic            force_go,
  input  wire pcw_set_t        req_set,
  input  wire logic [CHW-1:0]  req_chan,
  input  wire logic [DIR_W-1:0] req_dir,
  input  wire logic            busy,
  output logic                 wr_strobe,
  output pcw_set_t             set_in,
  output logic [CHW-1:0]       chan_addr,
  output logic [DIR_W-1:0]     dir_sel
);
  // ---------------------------------------------------------------
  // Fabric writer
  // ---------------------------------------------------------------
  logic [1:0] st_r;

  // Places values, waits for idle unless force_go is set, pulses the strobe, then scrambles its lines.
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= 2'h0;
      wr_strobe <= 1'b0;
      set_in    <= '0;
      chan_addr <= '0;
      dir_sel   <= DIR_NONE;
    end
    else
    begin
      case (st_r)
        2'h0:
        begin
          if (go)
          begin
            set_in    <= req_set;
            chan_addr <= req_chan;
            dir_sel   <= req_dir;
            st_r      <= 2'h1;
          end
        end
        2'h1:
        begin
          if (!busy || force_go)
          begin
            wr_strobe <= 1'b1;
            st_r      <= 2'h2;
          end
        end
        default:
        begin
          wr_strobe <= 1'b0;
          set_in    <= ~set_in;    // The held values are no longer valid.
          chan_addr <= ~chan_addr;
          dir_sel   <= ~dir_sel;
          st_r      <= 2'h0;
        end
      endcase
    end
  end
endmodule // pcw_user_model
`default_nettype wire

// ===== testbench/pcw_writer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module pcw_writer_tb_top;
  import pcw_pkg::*;
  localparam int NCH = 4;
  localparam int CHW = 2;
  logic              aclk, aresetn, ce, go, force_go, wr_strobe, busy, pma_sdata, pma_svalid;
  pcw_set_t          set_in, set_out, req_set;
  logic [CHW-1:0]    chan_addr, pma_chan, req_chan;
  logic [DIR_W-1:0]  dir_sel, req_dir;
  logic [AXI_AW-1:0] awaddr, araddr;
  logic              awvalid, awready, wvalid, wready, bvalid, bready;
  logic              arvalid, arready, rvalid, rready;
  logic [31:0]       wdata, rdata, rd;
  logic [3:0]        wstrb;
  logic [1:0]        bresp, rresp, rs;
  pcw_set_t          store [NCH];
  int                bad_count, n_checks, n_wr;

  // ---------------------------------------------------------------
  // Clock and instances
  // ---------------------------------------------------------------
  initial
  begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end

  pcw_writer #(.NCH(NCH)) i_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce),
    .wr_strobe(wr_strobe), .set_in(set_in), .chan_addr(chan_addr), .dir_sel(dir_sel),
    .busy(busy), .set_out(set_out), .pma_chan(pma_chan), .pma_sdata(pma_sdata),
    .pma_svalid(pma_svalid), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  pcw_user_model #(.CHW(CHW)) i_user (.aclk(aclk), .aresetn(aresetn), .go(go),
    .force_go(force_go), .req_set(req_set), .req_chan(req_chan), .req_dir(req_dir),
    .busy(busy), .wr_strobe(wr_strobe), .set_in(set_in), .chan_addr(chan_addr),
    .dir_sel(dir_sel));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input bit ok, input string m);
    n_checks++;
    if (!ok)
    begin
      bad_count++;
      $display("BAD t=%0t %s", $time, m);
    end
  endtask

  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // AXI4-Lite write: address and data offered together, bready held until bvalid.
  task automatic axi_wr(input logic [AXI_AW-1:0] a, input logic [31:0] d, output logic [1:0] r);
    int i;
    bit ta, tw, tr;
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      // Handshakes are judged on values settled before the rising edge.
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tr = bvalid;
      r  = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tr)
      begin
        bready <= 1'b0;
        break;
      end
    end
    // One edge passes so a following call never reassigns bready at once.
    @(posedge aclk);
    if (i == 50)
    begin
      chk(1'b0, "write response timeout");
      wrap_up();
    end
  endtask

  // AXI4-Lite read: rready held until rvalid.
  task automatic axi_rd(input logic [AXI_AW-1:0] a, output logic [31:0] d, output logic [1:0] r);
    int i;
    bit ta, tr;
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ta = arvalid && arready;
      tr = rvalid;
      d  = rdata;
      r  = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr)
      begin
        rready <= 1'b0;
        break;
      end
    end
    @(posedge aclk);
    if (i == 50)
    begin
      chk(1'b0, "read response timeout");
      wrap_up();
    end
  endtask

  // Asks the user model for a write without waiting for it.
  task automatic request(input logic [CHW-1:0] ch, input logic [DIR_W-1:0] d, input pcw_set_t s);
    req_set  <= s;
    req_chan <= ch;
    req_dir  <= d;
    go       <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
  endtask

  // Full channel write; checks busy length, serial word and merged outputs.
  task automatic do_write(input logic [CHW-1:0] ch, input logic [DIR_W-1:0] d, input pcw_set_t s);
    pcw_set_t    m;
    logic [13:0] sb;
    int          hi, nb, i;
    m = store[ch];
    if (d[DIR_TX_BIT]) {m.vod, m.preemp} = {s.vod, s.preemp};
    if (d[DIR_RX_BIT]) {m.eqdc, m.eq} = {s.eqdc, s.eq};
    store[ch] = m;
    n_wr++;
    request(ch, d, s);
    for (i = 0; i < 20 && busy !== 1'b1; i++)
    begin
      @(posedge aclk);
      #1;
    end
    if (i == 20)
    begin
      chk(1'b0, "busy never rose");
      wrap_up();
    end
    hi = 0;
    nb = 0;
    sb = '0;
    for (i = 0; i < 40 && busy === 1'b1; i++)
    begin
      if (pma_svalid === 1'b1)
      begin
        if (nb < 14) sb[nb] = pma_sdata;
        nb++;
      end
      hi++;
      @(posedge aclk);
      #1;
    end
    chk(hi == 16, "busy length");
    chk(nb == 14 && sb === m, "serial word");
    chk(set_out === m && pma_chan === ch, "settings out");
    @(posedge aclk);
  endtask

  // A request that must leave busy low.
  task automatic no_write(input logic [CHW-1:0] ch, input logic [DIR_W-1:0] d);
    bit seen;
    seen = 1'b0;
    request(ch, d, 14'h3fff);
    repeat (20)
    begin
      @(posedge aclk);
      #1;
      if (busy !== 1'b0) seen = 1'b1;
    end
    chk(!seen, "write not refused");
    @(posedge aclk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    {ce, aresetn, go, force_go, awvalid, wvalid, bready, arvalid, rready} = 9'h100;
    {req_set, req_chan, req_dir, awaddr, araddr, wdata, wstrb} = '0;
    {bad_count, n_checks, n_wr} = '0;
    store = '{default: '0};
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk($bits(set_out.vod) == 3 && $bits(set_out.preemp) == 5 && $bits(set_out.eqdc) == 2
      && $bits(set_out.eq) == 4, "field widths");
    chk(busy === 1'b0 && set_out === 14'h0, "reset outputs");
    axi_rd(REG_CTRL, rd, rs);
    chk(rs === RESP_OKAY && rd === 32'h1, "ctrl reset");
    axi_rd(4'hc, rd, rs);
    chk(rs === RESP_SLVERR, "unmapped read");
    axi_wr(4'hc, 32'h0, rs);
    chk(rs === RESP_SLVERR, "unmapped write");
    do_write(2'h1, DIR_TX, 14'h3fff);
    do_write(2'h1, DIR_RX, 14'h1555);
    do_write(2'h3, DIR_BOTH, 14'h2a5c);
    axi_rd(REG_LAST, rd, rs);
    chk(rd[15:0] === {DIR_BOTH, 14'h2a5c}, "last write");
    no_write(2'h0, DIR_NONE);
    axi_wr(REG_CTRL, 32'h0, rs);
    chk(rs === RESP_OKAY, "ctrl write");
    axi_rd(REG_CTRL, rd, rs);
    chk(rs === RESP_OKAY && rd === 32'h0, "ctrl cleared");
    no_write(2'h0, DIR_BOTH);
    axi_wr(REG_CTRL, 32'h1, rs);
    // A second strobe lands in mid-write and must be dropped.
    fork
      do_write(2'h2, DIR_TX, 14'h2c80);
      begin
        repeat (8) @(posedge aclk);
        force_go <= 1'b1;
        request(2'h2, DIR_BOTH, 14'h3fff);
        repeat (4) @(posedge aclk);
        force_go <= 1'b0;
      end
    join
    do_write(2'h2, DIR_RX, 14'h0003);
    do_write(2'h1, DIR_TX, 14'h0000);
    axi_rd(REG_STAT, rd, rs);
    chk(rd[31:16] === n_wr[15:0] && rd[0] === 1'b0, "status count");
    wrap_up();
  end
endmodule // pcw_writer_tb_top
`default_nettype wire
